// [dv/slf_rx_model.sv]
// Far-side receiver model: gathers each lane's octets into whole frames
`timescale 1ns/1ps
module slf_rx_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ce,
   input  wire logic [63:0] octets,
   input  wire logic [7:0]  valid,
   input  wire logic        start,
   output logic      [63:0] frame_ff [8],
   output logic      [4:0]  count_ff,
   output logic      [15:0] frames_ff
);
   //----------------------------------------
   // Frame capture
   //----------------------------------------
   logic [63:0] nxt_frame [8];
   logic [4:0]  nxt_count;
   logic [15:0] nxt_frames;

   // Octets come MSB first, so each new one shifts in at the bottom
   always_comb begin
      nxt_frame  = frame_ff;
      nxt_count  = count_ff;
      nxt_frames = frames_ff;
      if (ce && start) begin
         nxt_count  = 5'h01;
         nxt_frames = frames_ff + 16'h0001;
      end else if (ce && valid[0]) begin
         nxt_count = count_ff + 5'h01;
      end
      // Lanes are kept apart; the bench checks each lane against its own expected frame
      for (int i = 0; i < 8; i++) begin
         if (ce && valid[i]) nxt_frame[i] = {(start ? 56'h0 : frame_ff[i][55:0]), octets[i*8 +: 8]};
      end
   end

   // State registers
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_ff  <= '{default: 64'h0};
         count_ff  <= 5'h00;
         frames_ff <= 16'h0000;
      end else begin
         frame_ff  <= nxt_frame;
         count_ff  <= nxt_count;
         frames_ff <= nxt_frames;
      end
   end
endmodule

// [dv/tb_top.sv]
// Testbench: quad and single framers fed the same samples, judged per lane
`timescale 1ns/1ps
module tb_top;
   localparam int LIMIT = 3000;
   logic          clk, rst_n, ce, valid, rdy_q, rdy_s, fs_q, fs_s;
   logic [3:0]    mode;
   logic [7:0]    device_identifier_field, lv_q, lv_s, pd_q, pd_s, conv;
   logic [479:0]  data;
   logic [63:0]   oct_q, oct_s, devid;
   logic [23:0]   lane_index_field;
   logic [4:0]    focts, cnt_q, cnt_s;
   logic [8:0]    mbf;
   logic [63:0]   fr_q [8];
   logic [63:0]   fr_s [8];
   logic [15:0]   nfr_q, nfr_s;
   int            fail_count, n_checks, exp_frames, cyc;

   //----------------------------------------
   // Devices and receivers
   //----------------------------------------
   slf_framer dut_u (.CLK(clk), .RST_N(rst_n), .CE(ce), .LINK_MODE_SELECT(mode),
      .DEVICE_IDENTIFIER_FIELD(device_identifier_field), .SAMPLE_DATA(data), .SAMPLE_VALID(valid), .SAMPLE_READY(rdy_q),
      .LANE_OCTETS(oct_q), .LANE_VALID(lv_q), .LANE_POWER_DOWN(pd_q), .FRAME_START(fs_q),
      .LANE_INDEX_FIELD(lane_index_field), .LANE_DEVICE_ID(devid), .CONV_COUNT(conv), .FRAME_OCTETS(focts), .MB_FRAMES(mbf));
   slf_framer #(.VARIANT(slf_pkg::SLF_SINGLE)) dut_single_u (.CLK(clk), .RST_N(rst_n), .CE(ce),
      .LINK_MODE_SELECT(mode), .DEVICE_IDENTIFIER_FIELD(device_identifier_field), .SAMPLE_DATA(data), .SAMPLE_VALID(valid),
      .SAMPLE_READY(rdy_s), .LANE_OCTETS(oct_s), .LANE_VALID(lv_s), .LANE_POWER_DOWN(pd_s), .FRAME_START(fs_s),
      .LANE_INDEX_FIELD(), .LANE_DEVICE_ID(), .CONV_COUNT(), .FRAME_OCTETS(), .MB_FRAMES());
   slf_rx_model rx_q (.clk(clk), .rst_n(rst_n), .ce(ce), .octets(oct_q), .valid(lv_q), .start(fs_q),
      .frame_ff(fr_q), .count_ff(cnt_q), .frames_ff(nfr_q));
   slf_rx_model rx_s (.clk(clk), .rst_n(rst_n), .ce(ce), .octets(oct_s), .valid(lv_s), .start(fs_s),
      .frame_ff(fr_s), .count_ff(cnt_s), .frames_ff(nfr_s));

   // 50 MHz clock
   always #10 clk = ~clk;

   // Hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         fail_count++;
         conclude();
      end
   end

   //----------------------------------------
   // Helpers
   //----------------------------------------
   // Unique value for every word, channel and sample index below word 100
   function automatic logic [11:0] smp(input int w, input int c, input int n);
      return 12'(w * 40 + c * 10 + n + 1) ^ 12'hA50;
   endfunction

   function automatic logic [479:0] mk_word(input int w);
      logic [479:0] d;
      for (int i = 0; i < 40; i++) d[i*12 +: 12] = smp(w, i / 10, i % 10);
      return d;
   endfunction

   // Expected frame of one lane; two-octet frames sit in the low bits
   function automatic logic [63:0] exp_lane(input int w, input int md, input int ln, input bit one);
      logic [63:0] r;
      logic [11:0] s0, s1, t0, t1;
      r  = 64'h0;
      s0 = smp(w, (ln / 3) * 2, 0);
      s1 = smp(w, (ln / 3) * 2, 1);
      t0 = smp(w, (ln / 3) * 2 + 1, 0);
      t1 = smp(w, (ln / 3) * 2 + 1, 1);
      if (md == 0) begin
         for (int m = 0; m < 5; m++) r = {r[51:0], smp(w, ln / 2, 2 * m + ln % 2)};
         r = {r[59:0], 4'h0};
      end else if (ln % 3 == 0) r = {48'h0, s0, s1[11:8]};
      else if (ln % 3 == 1) r = {48'h0, s1[7:0], (one ? 8'h00 : t0[11:4])};
      else r = {48'h0, t0[3:0], t1};
      return r;
   endfunction

   task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // Waits, bounded, until frame exp_frames has n octets in the receiver
   task automatic wait_oct(input int n);
      int k;
      k = 0;
      while (!(nfr_q == 16'(exp_frames) && cnt_q == 5'(n)) && k < 60) begin
         @(negedge clk);
         k++;
      end
      chk(cnt_q, 64'(n));
   endtask

   //----------------------------------------
   // Scenarios
   //----------------------------------------
   task automatic t_reset();
      chk(pd_q, 8'hFF);
      chk(pd_s, 8'hFF);
      chk(lv_q, 8'h00);
   endtask

   // One frame, optionally frozen by CE just after octet 0
   task automatic t_frame(input int md, input bit pause);
      logic [63:0] e;
      exp_frames++;
      mode = 4'(md);
      @(negedge clk);
      data  = mk_word(exp_frames);
      valid = 1'b1;
      @(negedge clk);
      valid = 1'b0;
      if (pause) begin
         wait_oct(1);
         ce = 1'b0;
         repeat (3) @(negedge clk);
         e = exp_lane(exp_frames, md, 0, 0);
         chk(lv_q, (md == 0) ? 8'hFF : 8'h3F);
         chk(oct_q[7:0], (md == 0) ? e[55:48] : e[7:0]);
         ce = 1'b1;
      end
      wait_oct((md == 0) ? 8 : 2);
      for (int i = 0; i < ((md == 0) ? 8 : 6); i++) chk(fr_q[i], exp_lane(exp_frames, md, i, 0));
      for (int i = 0; i < 2; i++) chk(fr_s[i], exp_lane(exp_frames, md, i, 1));
      chk(pd_q, (md == 0) ? 8'h00 : 8'hC0);
      chk(pd_s, 8'hFC);
      chk(conv, (md == 0) ? 8'h08 : 8'h04);
      chk(focts, (md == 0) ? 5'h08 : 5'h02);
      chk(mbf, 9'h000);
      chk(lane_index_field, 24'hFAC688);
      chk(devid, {8{device_identifier_field}});
   endtask

   // Fill in an unsupported mode, then drain back to back in mode 0
   task automatic t_fill();
      mode = 4'h2;
      for (int w = 0; w < 20; w++) begin
         @(negedge clk);
         data  = mk_word(50 + w);
         valid = 1'b1;
      end
      @(negedge clk);
      valid = 1'b0;
      chk(rdy_q, 1'b0);
      chk(nfr_q, 16'(exp_frames));
      mode = 4'h0;
      for (int k = 0; k < 16; k++) begin
         exp_frames++;
         wait_oct(8);
         chk(fr_q[1], exp_lane(50 + k, 0, 1, 0));
         chk(fr_q[6], exp_lane(50 + k, 0, 6, 0));
         if (k < 15) begin
            @(negedge clk);
            chk(cnt_q, 5'h01);
         end
      end
      repeat (4) @(negedge clk);
      chk(nfr_q, 16'(exp_frames));
      chk(lv_q, 8'h00);
      chk(rdy_q, 1'b1);
   endtask

   // Main sequence
   initial begin
      clk        = 1'b0;
      rst_n      = 1'b0;
      ce         = 1'b1;
      mode       = 4'h0;
      device_identifier_field        = 8'h5A;
      data       = '0;
      valid      = 1'b0;
      fail_count = 0;
      n_checks   = 0;
      exp_frames = 0;
      cyc        = 0;
      repeat (10) @(negedge clk);
      t_reset();
      rst_n = 1'b1;
      t_frame(0, 1'b0);
      t_frame(0, 1'b1);
      t_frame(1, 1'b0);
      device_identifier_field = 8'hC3;
      t_frame(1, 1'b1);
      t_frame(0, 1'b0);
      t_fill();
      conclude();
   end
endmodule

// [src/slf_fifo.sv]
// Sample word FIFO with valid/ready on both sides
`timescale 1ns/1ps
module slf_fifo #(
   parameter int WIDTH = 32,
   parameter int DEPTH = 16
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic [WIDTH-1:0] in_data,
   input  wire logic             in_valid,
   output logic                  in_ready,
   output logic      [WIDTH-1:0] out_data,
   output logic                  out_valid,
   input  wire logic             out_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ff, rd_ff, nxt_wr, nxt_rd;
   logic [AW:0]   cnt_ff, nxt_cnt;
   logic          push, pop;

   //------------------------------------------------------------
   // Pointer and count update
   //------------------------------------------------------------
   always_comb begin
      push    = ce && in_valid && in_ready;
      pop     = ce && out_valid && out_ready;
      nxt_wr  = push ? AW'(wr_ff + 1'b1) : wr_ff;
      nxt_rd  = pop ? AW'(rd_ff + 1'b1) : rd_ff;
      nxt_cnt = (AW+1)'(cnt_ff + (AW+1)'(push) - (AW+1)'(pop));
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ff  <= '0;
         rd_ff  <= '0;
         cnt_ff <= '0;
      end else begin
         wr_ff  <= nxt_wr;
         rd_ff  <= nxt_rd;
         cnt_ff <= nxt_cnt;
      end
   end

   // Storage has no reset, so it maps to plain RAM
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_ff] <= in_data;
      end
   end

   assign in_ready  = (cnt_ff != (AW+1)'(DEPTH));
   assign out_valid = (cnt_ff != '0);
   assign out_data  = mem[rd_ff];
endmodule

// [src/slf_framer.sv]
// Top of the serial link sample framer: packs samples into per-lane octet frames
`timescale 1ns/1ps
module slf_framer #(
   parameter slf_pkg::slf_variant_t VARIANT = slf_pkg::SLF_QUAD,
   parameter int                    DEPTH   = slf_pkg::FIFO_DEPTH
) (
   input  wire logic                        CLK,
   input  wire logic                        RST_N,
   input  wire logic                        CE,
   input  wire logic [3:0]                  LINK_MODE_SELECT,
   input  wire logic [7:0]                  DEVICE_IDENTIFIER_FIELD,
   input  wire logic [slf_pkg::WORD_W-1:0]  SAMPLE_DATA,
   input  wire logic                        SAMPLE_VALID,
   output logic                             SAMPLE_READY,
   output logic [63:0]                      LANE_OCTETS,
   output logic [7:0]                       LANE_VALID,
   output logic [7:0]                       LANE_POWER_DOWN,
   output logic                             FRAME_START,
   output logic [23:0]                      LANE_INDEX_FIELD,
   output logic [63:0]                      LANE_DEVICE_ID,
   output logic [7:0]                       CONV_COUNT,
   output logic [4:0]                       FRAME_OCTETS,
   output logic [8:0]                       MB_FRAMES
);
   localparam int SW    = slf_pkg::SAMPLE_W;
   localparam int NLANE = (VARIANT == slf_pkg::SLF_SINGLE) ? slf_pkg::SINGLE_LANES : slf_pkg::MAX_LANES;

   typedef enum logic [1:0] {SLF_IDLE, SLF_SEND} slf_state_t;

   logic [slf_pkg::WORD_W-1:0] f_data;
   logic                       f_valid;
   logic                       f_ready;
   logic [63:0]                frame_bits [8];
   logic [7:0]                 octet      [8];
   logic [7:0]                 act_mask;
   logic [2:0]                 last_oct;
   logic                       mode_ok;

   slf_state_t st_ff, nxt_st;
   logic [2:0] oct_ff, nxt_oct;
   logic [3:0] mode_ff, nxt_mode;
   logic       load, adv;

   slf_fifo #(.WIDTH(slf_pkg::WORD_W), .DEPTH(DEPTH)) u_fifo (
      .clk       (CLK),
      .rst_n     (RST_N),
      .ce        (CE),
      .in_data   (SAMPLE_DATA),
      .in_valid  (SAMPLE_VALID),
      .in_ready  (f_ready),
      .out_data  (f_data),
      .out_valid (f_valid),
      .out_ready (load)
   );

   // Sample n of channel c from the FIFO word, channel-major, ten per channel
   function automatic logic [11:0] smp(input int c, input int n);
      smp = f_data[(c*10+n)*SW +: SW];
   endfunction

   //------------------------------------------------------------
   // Mode-dependent lane mask and frame length
   //------------------------------------------------------------
   always_comb begin
      act_mask = 8'h00;
      last_oct = 3'h0;
      mode_ok  = 1'b1;
      unique case (mode_ff)
         slf_pkg::MODE0: begin
            last_oct = 3'(slf_pkg::MODE0_OCTETS - 1);
            act_mask = (VARIANT == slf_pkg::SLF_QUAD) ? 8'hFF :
                       (VARIANT == slf_pkg::SLF_DUAL) ? 8'h0F : 8'h03;
         end
         slf_pkg::MODE1: begin
            last_oct = 3'(slf_pkg::MODE1_OCTETS - 1);
            act_mask = (VARIANT == slf_pkg::SLF_QUAD) ? 8'h3F :
                       (VARIANT == slf_pkg::SLF_DUAL) ? 8'h07 : 8'h03;
         end
         default: mode_ok = 1'b0;
      endcase
   end

   //------------------------------------------------------------
   // Frame packing; each lane builds a 64-bit, MSB-first image
   //------------------------------------------------------------
   for (genvar l = 0; l < 8; l++) begin : g_lane
      // First channel of this lane's mode 1 pair; lanes 6-7 wrap but are never active in mode 1
      localparam int CP = ((l / 3) % 2) * 2;
      logic [11:0] p0, p1, q0, q1;

      always_comb begin
         // Whole samples first: bit-selecting a function result is not portable
         p0 = smp(CP, 0);
         p1 = smp(CP, 1);
         q0 = smp(CP + 1, 0);
         q1 = smp(CP + 1, 1);
         frame_bits[l] = '0;
         if (mode_ff == slf_pkg::MODE0) begin
            // Lane pair per channel: even samples on even lane
            frame_bits[l] = {smp(l/2, l%2), smp(l/2, 2+l%2), smp(l/2, 4+l%2),
                             smp(l/2, 6+l%2), smp(l/2, 8+l%2), slf_pkg::TAIL};
         end else begin
            // Lanes 0-2 hold A/B, lanes 3-5 hold C/D in the same pattern
            unique case (l % 3)
               0: frame_bits[l][63:48] = {p0, p1[11:8]};
               1: frame_bits[l][63:48] = {p1[7:0], (VARIANT == slf_pkg::SLF_SINGLE) ? 8'h00 : q0[11:4]};
               default: frame_bits[l][63:48] = {q0[3:0], q1};
            endcase
         end
         if (!act_mask[l] || l >= NLANE) begin
            frame_bits[l] = '0;
         end
      end

      slf_lane_ser #(.BITS(64)) u_ser (
         .clk   (CLK),
         .rst_n (RST_N),
         .ce    (CE),
         .load  (load),
         .adv   (adv),
         .frame (frame_bits[l]),
         .octet (octet[l])
      );
   end

   //------------------------------------------------------------
   // Frame sequencer: one common octet counter keeps all lanes aligned
   //------------------------------------------------------------
   always_comb begin
      nxt_st   = st_ff;
      nxt_oct  = oct_ff;
      nxt_mode = mode_ff;
      load     = 1'b0;
      adv      = 1'b0;
      unique case (st_ff)
         SLF_IDLE: begin
            nxt_mode = LINK_MODE_SELECT; // Mode changes only between frames
            // A fresh mode is latched for one cycle before its first frame
            if (f_valid && mode_ok && LINK_MODE_SELECT == mode_ff) begin
               load    = 1'b1;
               nxt_oct = 3'h0;
               nxt_st  = SLF_SEND;
            end
         end
         SLF_SEND: begin
            if (oct_ff == last_oct) begin
               nxt_st = SLF_IDLE;
               if (f_valid && LINK_MODE_SELECT == mode_ff) begin
                  load    = 1'b1;
                  nxt_oct = 3'h0;
                  nxt_st  = SLF_SEND;
               end
            end else begin
               adv     = 1'b1;
               nxt_oct = 3'(oct_ff + 1'b1);
            end
         end
      endcase
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         st_ff   <= SLF_IDLE;
         oct_ff  <= 3'h0;
         mode_ff <= slf_pkg::MODE0;
      end else if (CE) begin
         st_ff   <= nxt_st;
         oct_ff  <= nxt_oct;
         mode_ff <= nxt_mode;
      end
   end

   //------------------------------------------------------------
   // Registered outputs
   //------------------------------------------------------------
   logic [63:0] nxt_lanes;
   logic [7:0]  nxt_lv;
   logic [7:0]  nxt_pd;
   logic [7:0]  nxt_m;
   logic [4:0]  nxt_f;

   always_comb begin
      for (int i = 0; i < 8; i++) begin
         nxt_lanes[i*8 +: 8] = (load || adv) ? octet[i] : 8'h00;
      end
      nxt_lv = (load || adv) ? (act_mask & 8'((1 << NLANE) - 1)) : 8'h00;
      nxt_pd = ~(act_mask & 8'((1 << NLANE) - 1));
      nxt_m  = 8'h00;
      for (int i = 0; i < 8; i++) begin
         nxt_m = 8'(nxt_m + {7'h00, act_mask[i]});
      end
      // Mode 0 advertises one converter per lane; mode 1 advertises real channels
      if (mode_ff == slf_pkg::MODE1) begin
         nxt_m = (VARIANT == slf_pkg::SLF_QUAD) ? 8'h04 : (VARIANT == slf_pkg::SLF_DUAL) ? 8'h02 : 8'h01;
      end else if (mode_ff != slf_pkg::MODE0) begin
         nxt_m = 8'h00;
      end
      nxt_f = (mode_ff == slf_pkg::MODE1) ? 5'(slf_pkg::MODE1_OCTETS) : 5'(slf_pkg::MODE0_OCTETS);
   end

   always_ff @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         LANE_OCTETS      <= '0;
         LANE_VALID       <= '0;
         LANE_POWER_DOWN  <= 8'hFF;
         FRAME_START      <= 1'b0;
         SAMPLE_READY     <= 1'b0;
         LANE_INDEX_FIELD <= '0;
         LANE_DEVICE_ID   <= '0;
         CONV_COUNT       <= '0;
         FRAME_OCTETS     <= '0;
         MB_FRAMES        <= '0;
      end else if (CE) begin
         LANE_OCTETS     <= nxt_lanes;
         LANE_VALID      <= nxt_lv;
         LANE_POWER_DOWN <= nxt_pd;
         FRAME_START     <= load;
         SAMPLE_READY    <= f_ready;
         for (int i = 0; i < 8; i++) begin
            LANE_INDEX_FIELD[i*3 +: 3] <= 3'(i);
            LANE_DEVICE_ID[i*8 +: 8]   <= DEVICE_IDENTIFIER_FIELD;
         end
         CONV_COUNT   <= nxt_m;
         FRAME_OCTETS <= nxt_f;
         MB_FRAMES    <= 9'h000; // (8B/10B modes only: no 64B/66B multiblock)
      end
   end

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   a_tail_zero: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && adv && mode_ff == slf_pkg::MODE0 && oct_ff == 3'(slf_pkg::MODE0_OCTETS - 2))
      |=> (LANE_OCTETS & 64'h0F0F0F0F0F0F0F0F) == 64'h0)
      else $error("tail nibble not zero");
   a_lane_idx: assert property (@(posedge CLK) disable iff (!RST_N)
      CE |=> LANE_INDEX_FIELD == 24'hFAC688)
      else $error("lane index wrong");
   a_pd_inactive: assert property (@(posedge CLK) disable iff (!RST_N)
      CE |=> (LANE_VALID & LANE_POWER_DOWN) == 8'h00)
      else $error("powered-down lane carries data");
   a_frame_len0: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && load && mode_ff == slf_pkg::MODE0) ##1 CE[*7]
      |=> oct_ff == 3'(slf_pkg::MODE0_OCTETS - 1) && LANE_VALID[0] && !FRAME_START)
      else $error("mode 0 frame length");
   a_start_valid: assert property (@(posedge CLK) disable iff (!RST_N)
      FRAME_START |-> LANE_VALID[0])
      else $error("frame start without lane 0 data");
   a_single_lanes: assert property (@(posedge CLK) disable iff (!RST_N)
      (VARIANT == slf_pkg::SLF_SINGLE) |-> LANE_VALID[7:4] == 4'h0)
      else $error("single variant used upper lanes");
   a_msb_first: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && load && mode_ff == slf_pkg::MODE0) |=> LANE_OCTETS[7:0] == $past(f_data[11:4]))
      else $error("sample not MSB first");
   a_single_fill: assert property (@(posedge CLK) disable iff (!RST_N)
      (CE && load && mode_ff == slf_pkg::MODE1 && VARIANT == slf_pkg::SLF_SINGLE) |-> frame_bits[1][55:48] == 8'h00)
      else $error("single mode 1 fill not zero");

   c_mode0: cover property (@(posedge CLK) FRAME_START && mode_ff == slf_pkg::MODE0);
   c_mode1: cover property (@(posedge CLK) FRAME_START && mode_ff == slf_pkg::MODE1);
   c_full:  cover property (@(posedge CLK) !f_ready);
endmodule

// [src/slf_lane_ser.sv]
// Per-lane octet shifter that presents one frame octet at a time
`timescale 1ns/1ps
module slf_lane_ser #(
   parameter int BITS = 64
) (
   input  wire logic            clk,
   input  wire logic            rst_n,
   input  wire logic            ce,
   input  wire logic            load,
   input  wire logic            adv,
   input  wire logic [BITS-1:0] frame,
   output logic      [7:0]      octet
);
   logic [BITS-1:0] sh_ff, nxt_sh;

   // Shift left so the first-sent octet is always on top
   always_comb begin
      nxt_sh = sh_ff;
      if (load) begin
         nxt_sh = frame;
      end else if (adv) begin
         nxt_sh = {sh_ff[BITS-9:0], 8'h00};
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_ff <= '0;
      end else if (ce) begin
         sh_ff <= nxt_sh;
      end
   end

   assign octet = nxt_sh[BITS-1 -: 8];
endmodule

// [src/slf_pkg.sv]
// Package: constants and types for the serial link sample framer
//----------------------------------------------------------------
// Operation
// - Quad and dual variants drive eight lanes, the single variant four; act_mask carries data on at most four lanes on dual parts and two on single.
// - Only the lowest lanes a mode needs carry data; every higher lane is powered down.
// - Each lane's index field equals its lane number and every lane carries the user device identifier.
// - Every tail bit position is driven to zero.
// - Each sample is sent most significant bit first.
// - The layout of samples in a frame follows the selected link mode and its transport parameters.
// - In 64B/66B modes frames per multiframe is fixed at 256 times E divided by F.
// - In flagged modes the advertised converter count equals the lane count.
// - Mode 0 puts even channel A samples on lane 0 and odd on lane 1 in eight octets ending with a tail nibble.
// - Mode 0 lanes 2/3 carry channel B, lanes 4/5 channel C and lanes 6/7 channel D on quad parts.
// - Mode 1 packs two samples of each channel in a pair into two-octet frames across three lanes.
// - Mode 1 on the single variant fills the channel B nibbles of lane 1 with zero.
// - Mode 1 on quad parts carries channels C and D on lanes 3 to 5 in the same pattern.
//----------------------------------------------------------------
package slf_pkg;

   typedef enum logic [1:0] {SLF_QUAD, SLF_DUAL, SLF_SINGLE} slf_variant_t;

   localparam int SAMPLE_W      = 12;
   localparam int MAX_LANES     = 8;
   localparam int SINGLE_LANES  = 4;
   localparam int MODE0_OCTETS  = 8;
   localparam int MODE1_OCTETS  = 2;
   localparam int MODE0_SAMPLES = 5;
   localparam int MODE1_SAMPLES = 2;
   localparam int FIFO_DEPTH    = 16;
   localparam int WORD_W        = 4 * 10 * SAMPLE_W;
   localparam int MB_FRAMES_NUM = 8 * 32;
   localparam logic [4:0] MODE0_K = 5'h08;
   localparam logic [4:0] MODE1_K = 5'h10;
   localparam logic [3:0] MODE0   = 4'h0;
   localparam logic [3:0] MODE1   = 4'h1;
   localparam logic [3:0] TAIL    = 4'h0;
   localparam logic [7:0] DID_RST = 8'h00;
   localparam logic [7:0] MODE_M0_FLAGGED = 8'h01;

   // Frames per multiframe in 64B/66B modes, fixed by E and F
   function automatic logic [8:0] mb_frames(input logic [1:0] e, input logic [3:0] f);
      mb_frames = 9'((MB_FRAMES_NUM * int'(e)) / ((f == 4'h0) ? 1 : int'(f)));
   endfunction

endpackage
